// *** design/aspo_uart.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aspo_uart (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Write address channel
  input  wire logic [aspo_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // Write data channel
  input  wire logic [aspo_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // Write response channel
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // Read address channel
  input  wire logic [aspo_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // Read data channel
  output logic [aspo_pkg::AXI_DW-1:0]    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Baud timer match, same clock
  input  wire logic                      timer_match_event,
  // Serial line
  input  wire logic                      serial_in,
  output logic                           serial_out,
  // Transmit start event
  output logic                           tx_irq
);
  import aspo_pkg::*;

  logic [7:0]  line_a_r;      // line_control_a
  logic [7:0]  line_b_r;      // line_control_b
  logic [7:0]  rx_hold_r;     // receive_holding
  logic [7:0]  tx_hold_r;     // transmit_holding
  logic        parity_fault_flag_r, framing_fault_flag_r, overrun_flag_r, full_r;
  logic        tx_done_r, tx_empty_r;
  logic        rd_arm_r;      // Status read seen, for receive side
  logic        arm_overrun_flag_r;    // Overrun state at that status read
  logic        wr_arm_r;      // Status read seen, for transmit side
  logic [7:0]  status_w;
  // Bus slave state
  logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [15:0] awaddr_r;
  logic [7:0]  wdata_r;
  logic        wlane_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [7:0]  rdata_r;
  logic        wr_go, rd_go, wr_hold_ok, rd_hold_go, rd_stat_go;
  // Baud and line
  logic [8:0]  div_w, div_cnt_r;
  logic        tick_w;
  logic        sin_s1_r, sin_s2_r, rxd_r;
  logic [6:0]  filt_len_w, filt_cnt_r;
  // Receiver
  aspo_phase_t rx_st_r;
  logic [3:0]  rx_rt_r;
  logic [2:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_s0_r, rx_s1_r, rx_vote, rx_eval, rx_stop1_r, rx_framing_fault_flag_r;
  logic        rx_par_bad_r, rx_end;
  // Transmitter
  aspo_phase_t tx_st_r;
  logic [3:0]  tx_sub_r;
  logic [2:0]  tx_bit_r;
  logic [7:0]  tx_sh_r;
  logic        tx_stop1_r, tx_bit_end, tx_load;
  logic        tx_par_r;      // Parity of the byte in flight; buffer may refill mid-frame

  // Status image
  assign status_w = {parity_fault_flag_r, framing_fault_flag_r, overrun_flag_r, full_r, tx_done_r, tx_empty_r, 2'h0};

  // Bus handshakes; one write and one read in flight
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h000000, rdata_r};
  assign wr_go      = aw_got_r && w_got_r && !bvalid_r;
  assign rd_go      = s_axi_arvalid && !rvalid_r;
  assign rd_stat_go = rd_go && (s_axi_araddr == ADDR_LINE_A);
  assign rd_hold_go = rd_go && (s_axi_araddr == ADDR_HOLD);
  // Held-byte write needs prior status read, enabled, empty buffer
  assign wr_hold_ok = wr_go && wlane_r && (awaddr_r == ADDR_HOLD) && wr_arm_r
                      && line_a_r[A_TX_EN] && tx_empty_r;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 16'h0000;
      wdata_r  <= 8'h00;
      wlane_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses get SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr_r == ADDR_LINE_A || awaddr_r == ADDR_LINE_B ||
                   awaddr_r == ADDR_HOLD) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data; write-only control_b reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 8'h00;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      if (rd_stat_go) begin
        rdata_r <= status_w;
      end else if (rd_hold_go) begin
        rdata_r <= rx_hold_r;
      end else if (s_axi_araddr == ADDR_LINE_B) begin
        rdata_r <= 8'h00;
      end else begin
        rdata_r <= 8'h00;
        rresp_r <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Control registers; writes at shared index hit control_a
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_a_r <= LINE_A_RST;
      line_b_r <= LINE_B_RST;
    end else if (wr_go && wlane_r) begin
      if (awaddr_r == ADDR_LINE_A) begin
        line_a_r <= wdata_r;
      end
      if (awaddr_r == ADDR_LINE_B) begin
        line_b_r <= wdata_r;
      end
    end
  end

  // Access order tracking: status read arms the buffer access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_arm_r   <= 1'b0;
      arm_overrun_flag_r <= 1'b0;
      wr_arm_r   <= 1'b0;
    end else begin
      if (rd_stat_go) begin
        rd_arm_r   <= 1'b1;
        arm_overrun_flag_r <= overrun_flag_r;
      end else if (rd_hold_go) begin
        rd_arm_r <= 1'b0;
      end
      if (rd_stat_go) begin
        wr_arm_r <= 1'b1;
      end else if (wr_go && awaddr_r == ADDR_HOLD) begin
        wr_arm_r <= 1'b0;
      end
    end
  end

  // Baud divisor from the shared select field
  always_comb begin
    div_w = DIV_13 << line_a_r[A_BAUD_HI:0];
    if (line_a_r[A_BAUD_HI:0] == BAUD_96) begin
      div_w = DIV_96;
    end
  end

  // Transfer clock tick; sixteen ticks make one bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 9'h000;
    end else if (div_cnt_r >= div_w - 9'h001) begin
      div_cnt_r <= 9'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 9'h001;
    end
  end
  // Timer source ticks once per timer match
  assign tick_w = (line_a_r[A_BAUD_HI:0] == BAUD_TIMER) ? timer_match_event
                  : (div_cnt_r == 9'h000);

  // Input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sin_s1_r <= 1'b1;
      sin_s2_r <= 1'b1;
    end else begin
      sin_s1_r <= serial_in;
      sin_s2_r <= sin_s1_r;
    end
  end

  // Filter length: level must persist this long to pass
  always_comb begin
    unique case (line_b_r[B_FILT_HI:B_FILT_LO])
      2'h1:    filt_len_w = FILT_31;
      2'h2:    filt_len_w = FILT_63;
      2'h3:    filt_len_w = FILT_127;
      default: filt_len_w = 7'h01;
    endcase
  end

  // Glitch filter; length 1 is a plain follower
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_r      <= 1'b1;
      filt_cnt_r <= 7'h00;
    end else if (sin_s2_r == rxd_r) begin
      filt_cnt_r <= 7'h00;
    end else if (filt_cnt_r >= filt_len_w - 7'h01) begin
      rxd_r      <= sin_s2_r;
      filt_cnt_r <= 7'h00;
    end else begin
      filt_cnt_r <= filt_cnt_r + 7'h01;
    end
  end

  // Majority of the three samples, judged at tick 9
  assign rx_vote = (rx_s0_r & rx_s1_r) | (rx_s0_r & rxd_r) | (rx_s1_r & rxd_r);
  assign rx_eval = tick_w && rx_st_r != ST_IDLE && rx_rt_r == RT_S2;
  // Frame ends at the middle of its last stop bit
  assign rx_end  = rx_eval && rx_st_r == ST_STOP && !(line_b_r[B_RX_STOP2] && !rx_stop1_r);

  // Receiver sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r      <= ST_IDLE;
      rx_rt_r      <= 4'h0;
      rx_bit_r     <= 3'h0;
      rx_sh_r      <= 8'h00;
      rx_s0_r      <= 1'b1;
      rx_s1_r      <= 1'b1;
      rx_stop1_r   <= 1'b0;
      rx_framing_fault_flag_r    <= 1'b0;
      rx_par_bad_r <= 1'b0;
    end else if (tick_w) begin
      rx_rt_r <= rx_rt_r + 4'h1;
      if (rx_rt_r == RT_S0) begin
        rx_s0_r <= rxd_r;
      end
      if (rx_rt_r == RT_S1) begin
        rx_s1_r <= rxd_r;
      end
      unique case (rx_st_r)
        ST_IDLE: begin
          // Overrun holds the receiver off until cleared
          if (!rxd_r && line_a_r[A_RX_EN] && !overrun_flag_r) begin
            rx_st_r    <= ST_START;
            rx_rt_r    <= 4'h1;
            rx_bit_r   <= 3'h0;
            rx_stop1_r <= 1'b0;
            rx_framing_fault_flag_r  <= 1'b0;
          end
        end
        ST_START: begin
          // A start that votes high was noise
          if (rx_rt_r == RT_S2) begin
            rx_st_r <= rx_vote ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_rt_r == RT_S2) begin
            rx_sh_r  <= {rx_vote, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == LAST_BIT) begin
              rx_st_r <= line_a_r[A_PAR_ON] ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_rt_r == RT_S2) begin
            // Even: total ones even; odd: total ones odd
            rx_par_bad_r <= (^{rx_sh_r, rx_vote}) != !line_a_r[A_EVEN];
            rx_st_r      <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_rt_r == RT_S2) begin
            rx_framing_fault_flag_r  <= rx_framing_fault_flag_r | !rx_vote;
            rx_stop1_r <= 1'b1;
            if (rx_end) begin
              rx_st_r <= ST_IDLE;
            end
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // Receive buffer and error flags; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_r <= HOLD_RST;
      full_r    <= 1'b0;
      overrun_flag_r    <= 1'b0;
      parity_fault_flag_r    <= 1'b0;
      framing_fault_flag_r    <= 1'b0;
    end else begin
      if (rd_hold_go && rd_arm_r) begin
        full_r <= 1'b0;
        parity_fault_flag_r <= 1'b0;
        framing_fault_flag_r <= 1'b0;
        if (arm_overrun_flag_r) begin
          overrun_flag_r <= 1'b0;
        end
      end
      if (rx_end) begin
        framing_fault_flag_r <= rx_framing_fault_flag_r | !rx_vote;
        parity_fault_flag_r <= line_a_r[A_PAR_ON] & rx_par_bad_r;
        if (full_r && !(rd_hold_go && rd_arm_r)) begin
          overrun_flag_r <= 1'b1;
        end else begin
          rx_hold_r <= rx_sh_r;
          full_r    <= 1'b1;
        end
      end
    end
  end

  // Transmit holding buffer and flags
  assign tx_load = tx_st_r == ST_IDLE && line_a_r[A_TX_EN] && !tx_empty_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_r  <= HOLD_RST;
      tx_empty_r <= 1'b1;
      tx_done_r  <= 1'b1;
      tx_irq     <= 1'b0;
    end else begin
      tx_irq <= tx_load;
      if (wr_hold_ok) begin
        tx_hold_r  <= wdata_r;
        tx_empty_r <= 1'b0;
      end
      if (tx_load) begin
        tx_empty_r <= 1'b1;
        tx_done_r  <= 1'b0;
      end else if (tx_st_r == ST_IDLE) begin
        tx_done_r <= 1'b1;
        if (!line_a_r[A_TX_EN]) begin
          tx_empty_r <= 1'b1;
        end
      end
    end
  end

  // Sixteen ticks per transmitted bit
  assign tx_bit_end = tick_w && tx_sub_r == RT_LAST;

  // Transmit sequencer; disable only stops in idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r    <= ST_IDLE;
      tx_sub_r   <= 4'h0;
      tx_bit_r   <= 3'h0;
      tx_sh_r    <= 8'h00;
      tx_par_r   <= 1'b0;
      tx_stop1_r <= 1'b0;
      serial_out <= 1'b1;
    end else begin
      if (tick_w) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      unique case (tx_st_r)
        ST_IDLE: begin
          serial_out <= 1'b1;
          if (tx_load) begin
            tx_st_r    <= ST_START;
            tx_sh_r    <= tx_hold_r;
            tx_par_r   <= ^tx_hold_r;
            tx_sub_r   <= 4'h0;
            tx_bit_r   <= 3'h0;
            tx_stop1_r <= 1'b0;
            serial_out <= 1'b0;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_st_r    <= ST_DATA;
            serial_out <= tx_sh_r[0];
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == LAST_BIT) begin
              tx_st_r    <= line_a_r[A_PAR_ON] ? ST_PAR : ST_STOP;
              serial_out <= line_a_r[A_PAR_ON] ? tx_par_r ^ !line_a_r[A_EVEN] : 1'b1;
            end else begin
              serial_out <= tx_sh_r[1];
            end
          end
        end
        ST_PAR: begin
          if (tx_bit_end) begin
            tx_st_r    <= ST_STOP;
            serial_out <= 1'b1;
          end
        end
        ST_STOP: begin
          if (tx_bit_end) begin
            tx_stop1_r <= 1'b1;
            if (!line_a_r[A_STOP2] || tx_stop1_r) begin
              tx_st_r <= ST_IDLE;
            end
          end
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // Checks
  line_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_r == ST_IDLE && $past(tx_st_r) == ST_IDLE && !$past(tx_load)) |-> serial_out)
    else $error("line not high while idle");
  start_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_st_r == ST_START) |-> !serial_out)
    else $error("start bit not low");
  empty_on_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_irq |-> tx_empty_r && !tx_done_r)
    else $error("empty flag not set on transmit event");
  status_reset_a: assert property (@(posedge aclk)
    (aresetn && !$past(aresetn)) |-> status_w[7:2] == 6'h03)
    else $error("status reset value wrong");
  overrun_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rx_end && full_r && !rd_hold_go) |=> overrun_flag_r && $stable(rx_hold_r))
    else $error("overrun changed receive buffer");
  div13_tick_a: assert property (@(posedge aclk)
    disable iff (!aresetn || line_a_r[A_BAUD_HI:0] != 3'h0)
    (div_cnt_r == 9'h000 && $past(div_cnt_r) == 9'h00c)
    |=> (div_cnt_r != 9'h000)[*8] ##1 (div_cnt_r != 9'h000)[*4] ##1 div_cnt_r == 9'h000)
    else $error("divide by 13 period wrong");
  rx_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_hold_go && rd_arm_r && !rx_end) |=> !full_r && !parity_fault_flag_r && !framing_fault_flag_r)
    else $error("receive flags not cleared");
  tx_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_hold_ok && !tx_load) |=> !tx_empty_r && (tx_load || tx_st_r != ST_IDLE))
    else $error("held byte not loaded");

endmodule : aspo_uart
`default_nettype wire

// *** design/aspo_pkg.sv ***
package aspo_pkg;
  // Bus widths
  localparam int          AXI_AW      = 16;
  localparam int          AXI_DW      = 32;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_LINE_A  = 12'hf95;
  localparam logic [11:0] IDX_LINE_B  = 12'hf96;
  localparam logic [11:0] IDX_HOLD    = 12'hf97;
  localparam logic [15:0] ADDR_LINE_A = {2'h0, IDX_LINE_A, 2'h0};
  localparam logic [15:0] ADDR_LINE_B = {2'h0, IDX_LINE_B, 2'h0};
  localparam logic [15:0] ADDR_HOLD   = {2'h0, IDX_HOLD, 2'h0};
  // Reset values
  localparam logic [7:0]  LINE_A_RST  = 8'h00;
  localparam logic [7:0]  LINE_B_RST  = 8'h00;
  localparam logic [7:0]  HOLD_RST    = 8'h00;
  // line_control_a fields
  localparam int          A_TX_EN     = 7;
  localparam int          A_RX_EN     = 6;
  localparam int          A_STOP2     = 5;
  localparam int          A_EVEN      = 4;
  localparam int          A_PAR_ON    = 3;
  localparam int          A_BAUD_HI   = 2;
  // line_control_b fields
  localparam int          B_RX_STOP2  = 0;
  localparam int          B_FILT_LO   = 1;
  localparam int          B_FILT_HI   = 2;
  // Baud source codes and oscillator divisors
  localparam logic [2:0]  BAUD_TIMER  = 3'h6;
  localparam logic [2:0]  BAUD_96     = 3'h7;
  localparam logic [8:0]  DIV_13      = 9'h00d;
  localparam logic [8:0]  DIV_96      = 9'h060;
  // Glitch filter lengths in oscillator periods
  localparam logic [6:0]  FILT_31     = 7'h1f;
  localparam logic [6:0]  FILT_63     = 7'h3f;
  localparam logic [6:0]  FILT_127    = 7'h7f;
  // Receiver sampling ticks, transmit last tick, last data bit
  localparam logic [3:0]  RT_S0       = 4'h7;
  localparam logic [3:0]  RT_S1       = 4'h8;
  localparam logic [3:0]  RT_S2       = 4'h9;
  localparam logic [3:0]  RT_LAST     = 4'hf;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Frame phases
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} aspo_phase_t;
endpackage : aspo_pkg

// *** dv/aspo_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aspo_line_model (
  // Clock
  input  wire logic       aclk,
  // Serial line, seen from the far end
  input  wire logic       serial_out,
  output logic            serial_in,
  // Frame format shared with the device
  input  wire logic       par_on,
  input  wire logic       even,
  input  wire logic       stop2,
  input  var  int         bit_cyc,
  // Decoded frame: fault bit above the byte
  output logic            got_valid,
  output logic [8:0]      got_frame
);
  logic [7:0] sh;  // Byte being decoded
  logic       bad; // Start, parity or stop fault
  int         i;   // Bit index
  // Line idles high between frames
  initial begin
    serial_in = 1'b1;
    got_valid = 1'b0;
    got_frame = 9'h000;
  end
  // Decoder: lock to the start edge, sample mid-bit
  always begin
    @(negedge serial_out);
    repeat (bit_cyc / 2) @(posedge aclk);
    bad = serial_out;
    for (i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      sh[i] = serial_out;
    end
    if (par_on) begin
      repeat (bit_cyc) @(posedge aclk);
      bad = bad | (serial_out !== (even ? ^sh : ~^sh));
    end
    for (i = 0; i < (stop2 ? 2 : 1); i++) begin
      repeat (bit_cyc) @(posedge aclk);
      bad = bad | !serial_out;
    end
    got_frame <= {bad, sh};
    got_valid <= 1'b1;
    @(posedge aclk);
    got_valid <= 1'b0;
  end
  // Sender; bp spoils parity, bs pulls the stop bit low
  task automatic send(input logic [7:0] b, input logic bp, input logic bs);
    logic [10:0] f;
    f = par_on ? {~bs, (even ? ^b : ~^b) ^ bp, b, 1'b0} : {1'b1, ~bs, b, 1'b0};
    @(posedge aclk);
    for (int j = 0; j < 11; j++) begin
      serial_in <= f[j];
      repeat (bit_cyc) @(posedge aclk);
    end
    serial_in <= 1'b1;
  endtask : send
  // Short low pulse that a filter must swallow
  task automatic glitch(input int n);
    @(posedge aclk);
    serial_in <= 1'b0;
    repeat (n) @(posedge aclk);
    serial_in <= 1'b1;
  endtask : glitch
endmodule : aspo_line_model
`default_nettype wire

// *** dv/aspo_uart_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module aspo_uart_test;
  import aspo_pkg::*;
  logic [15:0] awaddr, araddr;                // Bus addresses
  logic [31:0] wdata, rdata, seed;            // Bus data, random state
  logic [1:0]  bresp, rresp;                  // Responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        aclk, aresetn, tme, sin, sout, irq, gv;
  logic [8:0]  gf;                            // Frame from far end
  logic [7:0]  cfg, b;                        // Line setup, byte
  logic [7:0]  st[4] = '{8'h1c, 8'h9c, 8'h5c, 8'h3c}; // Status per receive case
  logic [33:0] exp_r[$], exp_b[$], exp_s[$];  // Expected results
  int          bit_cyc, miscompares, n_checks, cyc, irq_n, tcnt, k;
  aspo_uart aspo_uart_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_match_event(tme), .serial_in(sin),
    .serial_out(sout), .tx_irq(irq));
  aspo_line_model aspo_line_model_inst (.aclk(aclk), .serial_out(sout), .serial_in(sin),
    .par_on(cfg[3]), .even(cfg[4]), .stop2(cfg[5]), .bit_cyc(bit_cyc),
    .got_valid(gv), .got_frame(gf));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Timer match every 20 cycles, for the timer baud source
  always @(posedge aclk) begin
    tcnt <= (tcnt == 19) ? 0 : tcnt + 1;
    tme  <= (tcnt == 19);
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Write; each channel released at its own handshake
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    exp_b.push_back({32'h0, e});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  // Read; data noted for the watcher
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    exp_r.push_back({RESP_OKAY, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // Watcher: oldest note against each result; empty queue never matches
  always @(posedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_r.size() ? exp_r.pop_front() : '1);
    if (bvalid && bready) chk({32'h0, bresp}, exp_b.size() ? exp_b.pop_front() : '1);
    if (gv === 1'b1) chk({25'h0, gf}, exp_s.size() ? exp_s.pop_front() : '1);
    if (irq === 1'b1) irq_n++;
  end
  // Hang guard, about 1.4 times the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cfg, tcnt, tme, cyc, irq_n, miscompares, n_checks} = '0;
    bit_cyc = 208;
    seed = 32'hc5e8;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_LINE_A, 8'h0c);
    rd(ADDR_LINE_B, 8'h00);
    wr(16'h0100, 8'h00, RESP_SLVERR);
    wr(ADDR_LINE_B, 8'h02, RESP_OKAY);
    // Transmit: divide by 13, timer source, divide by 96
    for (k = 0; k < 3; k++) begin
      cfg = (k == 0) ? 8'hc0 : ((k == 1) ? 8'hee : 8'hdf);
      bit_cyc = (k == 0) ? 208 : ((k == 1) ? 320 : 1536);
      wr(ADDR_LINE_A, 8'h00, RESP_OKAY);
      wr(ADDR_LINE_A, cfg, RESP_OKAY);
      rd(ADDR_LINE_A, 8'h0c);
      seed = lfsr(seed);
      exp_s.push_back({26'h0, seed[7:0]});
      wr(ADDR_HOLD, seed[7:0], RESP_OKAY);
      rd(ADDR_LINE_A, 8'h04);
      exp_s.push_back({26'h0, seed[15:8]});
      wr(ADDR_HOLD, seed[15:8], RESP_OKAY);
      while (exp_s.size() != 0) @(posedge aclk);
      repeat (2 * bit_cyc) @(posedge aclk);
      wr(ADDR_HOLD, 8'h5a, RESP_OKAY);
      rd(ADDR_LINE_A, 8'h0c);
    end
    // Receive: glitch, good, bad parity, bad stop, overrun
    cfg = 8'hd8;
    bit_cyc = 208;
    wr(ADDR_LINE_A, 8'h00, RESP_OKAY);
    wr(ADDR_LINE_A, cfg, RESP_OKAY);
    aspo_line_model_inst.glitch(20);
    repeat (3000) @(posedge aclk);
    rd(ADDR_LINE_A, 8'h0c);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      b = seed[7:0];
      aspo_line_model_inst.send(b, k == 1, k == 2);
      if (k == 3) aspo_line_model_inst.send(~b, 1'b0, 1'b0);
      repeat (60) @(posedge aclk);
      rd(ADDR_LINE_A, st[k]);
      rd(ADDR_HOLD, b);
      rd(ADDR_LINE_A, 8'h0c);
    end
    chk(irq_n, 6);
    report_and_stop();
  end
endmodule : aspo_uart_test
`default_nettype wire
